/* File: rtl/etm_mac_tx.sv */
// MAC transmit end: client word intake and byte-wide frame generator.
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
module etm_mac_tx #(
  parameter int DEPTH = 8,
  parameter int LATENCY = etm_pkg::READY_LATENCY,
  parameter int STABLE_CYC = etm_pkg::STABLE_CYC
) (
  input wire logic aclk, // Transmit clock
  input wire logic aresetn, // Synchronous reset, low
  etm_tx_if.mac tx, // Client stream
  output logic link_en, // Frame byte valid on link
  output logic [7:0] link_byte, // Link byte
  output logic link_err, // Errored byte marker
  output logic [31:0] good_frames, // Frames sent without error
  output logic [31:0] bad_frames // Errored frames sent
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [15:0] STAB_LAST = 16'(STABLE_CYC - 1);
  localparam logic [3:0] PRE_LAST = 4'(etm_pkg::PRE_BYTES);
  localparam logic [3:0] FCS_LAST = 4'(etm_pkg::FCS_BYTES - 1);
  localparam logic [3:0] IPG_LAST = 4'(etm_pkg::IPG_BYTES - 1);
  localparam logic [15:0] MIN_LEN = 16'(etm_pkg::MIN_FRAME);
  localparam logic [AW+1:0] DEPTH_W = (AW+2)'(DEPTH);

  typedef struct packed {
    etm_pkg::etm_word_s [DEPTH-1:0] buf_w;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ready;
    logic [2:0] sr;
    logic in_frame;
    logic [15:0] stab;
    logic lanes;
    etm_pkg::etm_state_e st;
    logic [2:0] bi;
    logic [3:0] sc;
    logic [15:0] len;
    logic [31:0] crc;
    logic err;
    logic en;
    logic [7:0] byte_o;
    logic lerr;
    logic [31:0] good;
    logic [31:0] bad;
  } etm_mac_s;

  etm_mac_s q;
  etm_mac_s d;
  logic win;
  logic take;
  logic push;
  logic pop;
  logic [2:0] lastb;
  logic [7:0] b;
  logic [31:0] fcs;
  logic [AW+1:0] infl;
  etm_pkg::etm_word_s cur;

  always_comb begin
    d = q;
    push = 1'b0;
    pop = 1'b0;
    b = 8'h00;
    fcs = 32'h00000000;
    cur = q.buf_w[q.rp];
    lastb = cur.last ? 3'(3'h7 - cur.empty) : 3'h7; // RL9
    win = etm_pkg::etm_win(LATENCY, q.ready, q.sr); // RL12 RL13
    take = tx.tx_word_valid && win;
    d.sr = {q.sr[1:0], q.ready};

    // Lanes come up a fixed time after reset
    if (!q.lanes) begin
      if (q.stab == STAB_LAST) begin
        d.lanes = 1'b1; // RL2
      end else begin
        d.stab = q.stab + 16'h0001;
      end
    end

    // Intake; words outside a frame are not considered
    if (take) begin
      if (tx.tx_frame_first && tx.tx_frame_last) begin
        d.in_frame = 1'b0; // RL8
      end else if (tx.tx_frame_first || q.in_frame) begin
        push = 1'b1; // RL17
        d.in_frame = !tx.tx_frame_last;
      end
    end
    if (push) begin
      d.buf_w[q.wp].data = tx.tx_word_in; // RL3
      d.buf_w[q.wp].empty = tx.tx_unused_bytes;
      d.buf_w[q.wp].first = tx.tx_frame_first;
      d.buf_w[q.wp].last = tx.tx_frame_last;
      d.buf_w[q.wp].bad = tx.tx_frame_bad && tx.tx_frame_last; // RL10
      d.wp = q.wp + 1'b1;
    end

    d.en = 1'b0;
    d.lerr = 1'b0;
    d.byte_o = 8'h00;
    unique case (q.st)
      etm_pkg::ST_IDLE: begin
        if (q.cnt != '0 && q.lanes) begin
          d.st = etm_pkg::ST_PRE; // RL16
          d.sc = 4'h0;
        end
      end
      etm_pkg::ST_PRE: begin
        d.en = 1'b1;
        d.byte_o = (q.sc == PRE_LAST) ? etm_pkg::SFD_BYTE
                                      : etm_pkg::PRE_BYTE; // RL16
        d.sc = q.sc + 4'h1;
        if (q.sc == PRE_LAST) begin
          d.st = etm_pkg::ST_DATA;
          d.crc = etm_pkg::CRC_INIT;
          d.len = 16'h0000;
          d.bi = 3'h0;
          d.err = 1'b0;
        end
      end
      etm_pkg::ST_DATA: begin
        d.en = 1'b1;
        if (q.cnt == '0) begin
          // Client starved the frame: no idle is inserted, it is spoiled
          d.lerr = 1'b1; // RL17
          d.err = 1'b1;
        end else begin
          b = cur.data[8*(7-q.bi) +: 8]; // RL7
          d.byte_o = b;
          d.crc = etm_pkg::etm_crc_byte(q.crc, b); // RL16
          d.len = q.len + 16'h0001;
          if (q.bi == lastb) begin
            pop = 1'b1;
            d.bi = 3'h0;
            if (cur.last) begin
              d.err = q.err || cur.bad; // RL10
              d.sc = 4'h0;
              d.st = (d.len < MIN_LEN) ? etm_pkg::ST_PAD
                                       : etm_pkg::ST_FCS; // RL16
            end
          end else begin
            d.bi = q.bi + 3'h1;
          end
        end
      end
      etm_pkg::ST_PAD: begin
        d.en = 1'b1;
        d.byte_o = 8'h00; // RL16
        d.crc = etm_pkg::etm_crc_byte(q.crc, 8'h00);
        d.len = q.len + 16'h0001;
        if (d.len == MIN_LEN) begin
          d.st = etm_pkg::ST_FCS;
          d.sc = 4'h0;
        end
      end
      etm_pkg::ST_FCS: begin
        // An errored frame leaves with a deliberately wrong checksum
        fcs = q.err ? q.crc : ~q.crc;
        d.en = 1'b1;
        d.lerr = q.err;
        d.byte_o = fcs[8*q.sc[1:0] +: 8]; // RL16
        d.sc = q.sc + 4'h1;
        if (q.sc == FCS_LAST) begin
          d.st = etm_pkg::ST_GAP;
          d.sc = 4'h0;
          if (q.err) begin
            d.bad = q.bad + 32'h00000001;
          end else begin
            d.good = q.good + 32'h00000001; // RL11
          end
        end
      end
      etm_pkg::ST_GAP: begin
        d.sc = q.sc + 4'h1; // RL16
        if (q.sc == IPG_LAST) begin
          d.st = etm_pkg::ST_IDLE; // RL17
        end
      end
      default: begin
        d.st = etm_pkg::ST_IDLE;
      end
    endcase

    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);

    // Room must cover every window already promised by earlier ready
    infl = (LATENCY == 0) ? '0
         : (AW+2)'(q.ready) + (AW+2)'(q.sr[0]) + (AW+2)'(q.sr[1]);
    d.ready = d.lanes && (((AW+2)'(d.cnt) + infl) < DEPTH_W); // RL13
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d; // RL1
    end
  end

  assign tx.tx_accept = q.ready;
  assign tx.tx_lanes_stable = q.lanes;
  assign link_en = q.en;
  assign link_byte = q.byte_o;
  assign link_err = q.lerr;
  assign good_frames = q.good;
  assign bad_frames = q.bad;
endmodule

/* File: rtl/etm_pkg.sv */
// Shared constants, types and helpers for the transmit client stream.
// Overview of operation
// [RL1] MAC drives client signals on one transmit clock
// [RL2] Clock usable once lanes-stable indication is high
// [RL3] 64-bit word, bit 63 MSB, bytes high-to-low
// [RL4] Client never sends frames under nine bytes
// [RL5] Client starts a frame only when complete
// [RL6] Client holds valid high from first to last
// [RL7] First byte of frame in the top byte
// [RL8] MAC drops frames with first and last together
// [RL9] Three-bit count of unused bytes on last
// [RL10] Error input honoured only on the last word
// [RL11] Errored frames excluded from good frame counter
// [RL12] Latency zero: accept in the cycle of ready
// [RL13] Latency three: accept three cycles after ready
// [RL14] Latency zero: client holds data while not ready
// [RL15] Latency three: client holds data per delayed ready
// [RL16] MAC adds gap, preamble, padding and checksum
// [RL17] Frames sent without idles, idles between frames
package etm_pkg;
  localparam int WORD_W = 64;
  localparam int EMPTY_W = 3;
  localparam int READY_LATENCY = 0;
  localparam int TX_CLK_KHZ = 390625;
  localparam int CLK_MHZ = 125;
  localparam int STABLE_NS = 800;
  localparam int STABLE_CYC = (STABLE_NS * CLK_MHZ + 999) / 1000;
  localparam int PRE_BYTES = 7;
  localparam logic [7:0] PRE_BYTE = 8'h55;
  localparam logic [7:0] SFD_BYTE = 8'hd5;
  localparam int MIN_FRAME = 60;
  localparam int FCS_BYTES = 4;
  localparam int IPG_BYTES = 12;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam int ADDR_W = 12;
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_LEVEL = 12'h008;
  localparam int CTRL_EN = 0;
  localparam logic CTRL_EN_RST = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PRE = 3'h1,
    ST_DATA = 3'h3,
    ST_PAD = 3'h2,
    ST_FCS = 3'h6,
    ST_GAP = 3'h7
  } etm_state_e;

  typedef struct packed {
    logic bad;
    logic last;
    logic first;
    logic [EMPTY_W-1:0] empty;
    logic [WORD_W-1:0] data;
  } etm_word_s;

  // One byte of the reflected Ethernet checksum
  function automatic logic [31:0] etm_crc_byte(input logic [31:0] c,
                                               input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Acceptance window seen identically by both ends
  function automatic logic etm_win(input int lat, input logic rdy,
                                   input logic [2:0] sr);
    return (lat == 0) ? rdy : sr[2];
  endfunction
endpackage

/* File: rtl/etm_tx_if.sv */
// Transmit client stream between user client logic and the MAC.
interface etm_tx_if (
  input wire logic aclk // Transmit client clock
);
  logic [63:0] tx_word_in;
  logic tx_word_valid;
  logic tx_frame_first;
  logic tx_frame_last;
  logic [2:0] tx_unused_bytes;
  logic tx_frame_bad;
  logic tx_accept;
  logic tx_lanes_stable;

  modport mac (
    input aclk, tx_word_in, tx_word_valid, tx_frame_first, tx_frame_last,
    input tx_unused_bytes, tx_frame_bad,
    output tx_accept, tx_lanes_stable
  );
  modport client (
    input aclk, tx_accept, tx_lanes_stable,
    output tx_word_in, tx_word_valid, tx_frame_first, tx_frame_last,
    output tx_unused_bytes, tx_frame_bad
  );
endinterface

/* File: rtl/etm_client_tx.sv */
// Client end: user stream into frame store, AXI4-Lite control, stream out.
module etm_client_tx #(
  parameter int MEM_DEPTH = 32,
  parameter int LATENCY = etm_pkg::READY_LATENCY
) (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Synchronous reset, low
  etm_tx_if.client tx, // Stream to MAC
  input wire logic [63:0] u_data, // User word
  input wire logic u_valid, // User word valid
  input wire logic u_first, // User frame first
  input wire logic u_last, // User frame last
  input wire logic [2:0] u_empty, // User unused bytes
  input wire logic u_bad, // User frame error
  output logic u_ready, // Buffer can take
  input wire logic [11:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [11:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);
  localparam int MW = $clog2(MEM_DEPTH);
  localparam logic [MW:0] MEM_FULL = (MW+1)'(MEM_DEPTH);

  typedef struct packed {
    etm_pkg::etm_word_s [MEM_DEPTH-1:0] mem;
    etm_pkg::etm_word_s [1:0] sk;
    logic [1:0] skn;
    logic urdy;
    logic [MW-1:0] wp;
    logic [MW-1:0] rp;
    logic [MW:0] mcnt;
    logic [MW:0] fcnt;
    etm_pkg::etm_word_s ow;
    logic ov;
    logic in_tx;
    logic [2:0] sr;
    logic en;
    logic [15:0] sent;
    logic [15:0] drops;
    logic awh;
    logic wh;
    logic [11:0] awa;
    logic [31:0] wd;
    logic ws;
    logic awr;
    logic wr;
    logic bv;
    logic [1:0] br;
    logic arr;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
  } etm_cli_s;

  etm_cli_s q;
  etm_cli_s d;
  etm_pkg::etm_word_s h;
  logic [1:0] n;
  logic skpop;
  logic wr_m;
  logic win;
  logic take;
  logic start;
  logic ld;

  always_comb begin
    d = q;
    h = q.sk[0];
    n = q.skn;
    wr_m = 1'b0;
    // Single-word frames are under nine bytes and never leave
    skpop = (q.skn != 2'h0) && ((h.first && h.last) || q.mcnt != MEM_FULL);
    if (skpop) begin
      if (h.first && h.last) begin
        d.drops = q.drops + 16'h0001; // RL4
      end else begin
        wr_m = 1'b1;
        d.mem[q.wp] = h;
        d.wp = q.wp + 1'b1;
      end
      d.sk[0] = q.sk[1];
      n = n - 2'h1;
    end
    if (u_valid && q.urdy) begin
      d.sk[n] = '{bad: u_bad, last: u_last, first: u_first,
                  empty: u_empty, data: u_data};
      n = n + 2'h1;
    end
    d.skn = n;
    d.urdy = (n != 2'h2);

    // Send side: a frame starts only once it lies whole in the store
    win = etm_pkg::etm_win(LATENCY, tx.tx_accept, q.sr);
    d.sr = {q.sr[1:0], tx.tx_accept};
    take = q.ov && win;
    start = !q.in_tx && q.fcnt != '0 && q.en && tx.tx_lanes_stable; // RL5
    ld = (!q.ov || take) && q.mcnt != '0 && (q.in_tx || start);
    if (ld) begin
      d.ow = q.mem[q.rp]; // RL14 RL15
      d.rp = q.rp + 1'b1;
      d.ov = 1'b1; // RL6
      if (start) begin
        d.in_tx = 1'b1;
      end
      if (q.mem[q.rp].last) begin
        d.in_tx = 1'b0;
      end
    end else if (take) begin
      d.ov = 1'b0;
    end
    if (take && q.ow.last) begin
      d.sent = q.sent + 16'h0001;
    end
    d.mcnt = q.mcnt + (MW+1)'(wr_m) - (MW+1)'(ld);
    d.fcnt = q.fcnt + (MW+1)'(wr_m && h.last) - (MW+1)'(ld && start);

    // AXI4-Lite slave, address and data taken in either order
    if (s_axi_awvalid && q.awr) begin
      d.awh = 1'b1;
      d.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wr) begin
      d.wh = 1'b1;
      d.wd = s_axi_wdata;
      d.ws = s_axi_wstrb[0];
    end
    if (q.bv && s_axi_bready) begin
      d.bv = 1'b0;
    end
    if (q.awh && q.wh && !q.bv) begin
      d.awh = 1'b0;
      d.wh = 1'b0;
      d.bv = 1'b1;
      d.br = etm_pkg::RESP_SLVERR;
      if ({q.awa[11:2], 2'h0} == etm_pkg::REG_CTRL) begin
        d.br = etm_pkg::RESP_OKAY;
        if (q.ws) begin
          d.en = q.wd[etm_pkg::CTRL_EN];
        end
      end
    end
    d.awr = !d.awh && !d.bv;
    d.wr = !d.wh && !d.bv;
    if (q.rv && s_axi_rready) begin
      d.rv = 1'b0;
    end
    if (s_axi_arvalid && q.arr) begin
      d.rv = 1'b1;
      d.rr = etm_pkg::RESP_OKAY;
      unique case ({s_axi_araddr[11:2], 2'h0})
        etm_pkg::REG_CTRL: d.rd = {31'h00000000, q.en};
        etm_pkg::REG_STATUS: d.rd = {q.drops, q.sent};
        etm_pkg::REG_LEVEL: d.rd = {16'(q.fcnt), 16'(q.mcnt)};
        default: begin
          d.rd = 32'h00000000;
          d.rr = etm_pkg::RESP_SLVERR;
        end
      endcase
    end
    d.arr = !d.rv;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.en <= etm_pkg::CTRL_EN_RST;
    end else begin
      q <= d;
    end
  end

  assign tx.tx_word_in = q.ow.data; // RL3
  assign tx.tx_word_valid = q.ov;
  assign tx.tx_frame_first = q.ow.first; // RL7
  assign tx.tx_frame_last = q.ow.last;
  assign tx.tx_unused_bytes = q.ow.empty; // RL9
  assign tx.tx_frame_bad = q.ow.bad;
  assign u_ready = q.urdy;
  assign s_axi_awready = q.awr;
  assign s_axi_wready = q.wr;
  assign s_axi_bvalid = q.bv;
  assign s_axi_bresp = q.br;
  assign s_axi_arready = q.arr;
  assign s_axi_rvalid = q.rv;
  assign s_axi_rdata = q.rd;
  assign s_axi_rresp = q.rr;
endmodule

/* File: bench/etm_tx_checker.sv */
// Concurrent checks on the client-to-MAC transmit stream.
module etm_tx_checker #(
  parameter int STABLE_CYC = 4
) (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, low
  input wire logic [63:0] tx_word_in, // Frame word
  input wire logic tx_word_valid, // Word valid
  input wire logic tx_frame_first, // First word
  input wire logic tx_frame_last, // Last word
  input wire logic [2:0] tx_unused_bytes, // Unused bytes
  input wire logic tx_frame_bad, // Frame error
  input wire logic tx_accept, // MAC ready
  input wire logic tx_lanes_stable // Lanes stable
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STB_MAX = STABLE_CYC + 2;
  logic open_q;
  logic open_d;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence taken;
    tx_word_valid && tx_accept;
  endsequence
  sequence held;
    tx_word_valid && !tx_accept;
  endsequence

  // Frame open from a taken first word until its last word is taken
  always_comb begin
    open_d = open_q;
    if (tx_word_valid && tx_accept && tx_frame_last) begin
      open_d = 1'b0;
    end else if (tx_word_valid && tx_accept && tx_frame_first) begin
      open_d = 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    open_q <= aresetn ? open_d : 1'b0;
  end

  lanes_hold_a: assert property (tx_lanes_stable |=> tx_lanes_stable)
    else $error("lanes stable dropped");
  ready_lanes_a: assert property (tx_accept |-> tx_lanes_stable)
    else $error("ready before lanes stable");
  lanes_rise_a: assert property (
    $rose(aresetn) |-> ##[1:STB_MAX] tx_lanes_stable)
    else $error("lanes stable late");
  valid_run_a: assert property (open_q |-> tx_word_valid)
    else $error("valid gap inside frame");
  hold_word_a: assert property (
    held |=> tx_word_valid && $stable(tx_word_in))
    else $error("word changed while not accepted");
  hold_qual_a: assert property (held |=> $stable({tx_frame_first,
    tx_frame_last, tx_unused_bytes, tx_frame_bad}))
    else $error("qualifiers changed while not accepted");
  frame_start_a: assert property ((taken ##0 (tx_frame_first
    && !tx_frame_last)) |=> tx_word_valid)
    else $error("frame not continued next cycle");
  accept_soon_a: assert property (
    tx_word_valid |-> ##[0:300] tx_accept)
    else $error("word never accepted");
endmodule

/* File: bench/test_tx_mac_client_stream.sv */
// Testbench: client end and MAC end joined, user stream in, link out.
module test_tx_mac_client_stream;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STB = 4;
  logic aclk, aresetn, u_valid, u_first, u_last, u_bad, u_ready;
  logic [63:0] u_data;
  logic [2:0] u_empty;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, good_frames, bad_frames, rnd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, link_en, link_err;
  logic [7:0] link_byte;
  logic u_ready3, link_en3, link_err3, u_take;
  logic [7:0] link_byte3;
  logic [31:0] good3, bad3;
  logic [8:0] exp3_q[$];
  int len3_q[$];
  int run3 = 0;
  // Both stores take a word only together, so they see one stream
  assign u_take = u_valid && u_ready && u_ready3;
  logic [8:0] exp_q[$];
  int len_q[$];
  int err_total = 0, comparisons = 0, cyc = 0, run = 0, stalls = 0;

  etm_tx_if tx (.aclk);
  etm_mac_tx #(.STABLE_CYC(STB)) u_etm_mac_tx (.aclk, .aresetn, .tx,
    .link_en, .link_byte, .link_err, .good_frames, .bad_frames);
  etm_client_tx u_etm_client_tx (.aclk, .aresetn, .tx, .u_data,
    .u_valid(u_take), .u_first, .u_last, .u_empty, .u_bad, .u_ready,
    .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // Second pair runs the same frames with a ready latency of three
  etm_tx_if tx3 (.aclk);
  etm_mac_tx #(.LATENCY(3), .STABLE_CYC(STB)) u_etm_mac_tx_l3 (.aclk,
    .aresetn, .tx(tx3), .link_en(link_en3), .link_byte(link_byte3),
    .link_err(link_err3), .good_frames(good3), .bad_frames(bad3));
  etm_client_tx #(.LATENCY(3)) u_etm_client_tx_l3 (.aclk, .aresetn,
    .tx(tx3), .u_data, .u_valid(u_take), .u_first, .u_last, .u_empty,
    .u_bad, .u_ready(u_ready3), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(),
    .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready);
  etm_tx_checker #(.STABLE_CYC(STB)) u_etm_tx_checker (.aclk, .aresetn,
    .tx_word_in(tx.tx_word_in), .tx_word_valid(tx.tx_word_valid),
    .tx_frame_first(tx.tx_frame_first), .tx_frame_last(tx.tx_frame_last),
    .tx_unused_bytes(tx.tx_unused_bytes), .tx_frame_bad(tx.tx_frame_bad),
    .tx_accept(tx.tx_accept), .tx_lanes_stable(tx.tx_lanes_stable));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [31:0] crc8(input logic [31:0] c,
                                       input logic [7:0] b);
    c = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
    end
    return c;
  endfunction

  task automatic check(input string what, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic conclude();
    $display("counts: %0d compared, %0d wrong", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check("bresp", r, s_axi_bresp);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check("rresp", r, s_axi_rresp);
    check("rdata", e, s_axi_rdata);
  endtask

  // One user word, held until taken; random idle cycles gap the user stream
  task automatic put(input logic [63:0] d, input logic f, l,
                     input logic [2:0] e, input logic b);
    u_data <= d;
    u_first <= f;
    u_last <= l;
    u_empty <= e;
    u_bad <= b;
    u_valid <= 1'b1;
    do begin
      @(posedge aclk);
      if (!(u_ready && u_ready3)) stalls++;
    end while (!(u_ready && u_ready3));
    rnd = xs(rnd);
    if (rnd[0]) begin
      u_valid <= 1'b0;
      @(posedge aclk);
    end
  endtask

  // bp: 0 no error, 1 error on last word, 2 error on first word only
  task automatic send(input int len, input int bp);
    logic [7:0] b[$];
    logic [8:0] e[$];
    logic [63:0] d;
    logic [31:0] c;
    int n;
    n = (len + 7) / 8;
    c = 32'hffffffff;
    for (int i = 0; i < len; i++) begin
      rnd = xs(rnd);
      b.push_back(rnd[7:0]);
    end
    if (n > 1) begin
      for (int i = 0; i < 8; i++) begin
        e.push_back({1'b0, i < 7 ? 8'h55 : 8'hd5});
      end
      for (int i = 0; i < len || i < 60; i++) begin
        d[7:0] = i < len ? b[i] : 8'h00;
        c = crc8(c, d[7:0]);
        e.push_back({1'b0, d[7:0]});
      end
      if (bp != 1) c = ~c;
      for (int i = 0; i < 4; i++) begin
        e.push_back({bp == 1, c[8*i +: 8]});
      end
      foreach (e[i]) begin
        exp_q.push_back(e[i]);
        exp3_q.push_back(e[i]);
      end
      len_q.push_back(12 + (len > 60 ? len : 60));
      len3_q.push_back(12 + (len > 60 ? len : 60));
    end
    for (int w = 0; w < n; w++) begin
      d = '0;
      for (int k = 0; k < 8; k++) begin
        if (8*w+k < len) d[63-8*k -: 8] = b[8*w+k];
      end
      put(d, w == 0, w == n-1, 3'(8*n-len), (bp == 1 && w == n-1) ||
          (bp == 2 && w == 0));
    end
  endtask

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // Hang guard: the whole run needs under two thousand cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end
  always @(posedge aclk) begin
    if (aresetn && link_en) begin
      run++;
      if (exp_q.size() == 0) check("extra link byte", 0, 1);
      else check("link byte", 32'(exp_q.pop_front()),
                 {23'h0, link_err, link_byte});
    end else if (run != 0) begin
      check("frame length", len_q.pop_front(), run);
      run = 0;
    end
  end
  always @(posedge aclk) begin
    if (aresetn && link_en3) begin
      run3++;
      if (exp3_q.size() == 0) check("extra link3 byte", 0, 1);
      else check("link3 byte", 32'(exp3_q.pop_front()),
                 {23'h0, link_err3, link_byte3});
    end else if (run3 != 0) begin
      check("frame3 length", len3_q.pop_front(), run3);
      run3 = 0;
    end
  end

  initial begin
    aresetn = 1'b0;
    rnd = 32'ha6dd;
    {u_valid, u_first, u_last, u_bad, u_empty, u_data} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(etm_pkg::REG_CTRL, 32'h0, etm_pkg::RESP_OKAY);
    rd(12'h00c, 32'h0, etm_pkg::RESP_SLVERR);
    wr(etm_pkg::REG_STATUS, 32'h1, etm_pkg::RESP_SLVERR);
    $display("test registers done");
    fork
      begin
        send(9, 0);
        for (int l = 57; l <= 64; l++) send(l, 0);
        send(8, 0);
        send(20, 1);
        send(30, 2);
        u_valid <= 1'b0;
      end
      begin
        // Frames pile up while disabled until the store refuses
        repeat (300) @(posedge aclk);
        check("user stalls", 1, stalls > 0);
        rd(etm_pkg::REG_LEVEL, {16'h0004, 16'h0020}, etm_pkg::RESP_OKAY);
        wr(etm_pkg::REG_CTRL, 32'h1, etm_pkg::RESP_OKAY);
      end
    join
    while (exp_q.size() + exp3_q.size() != 0 || link_en || link_en3) begin
      @(posedge aclk);
    end
    repeat (20) @(posedge aclk);
    $display("test stream done");
    check("good frames", 10, good_frames);
    check("bad frames", 1, bad_frames);
    check("good frames l3", 10, good3);
    check("bad frames l3", 1, bad3);
    rd(etm_pkg::REG_STATUS, {16'h0001, 16'h000b}, etm_pkg::RESP_OKAY);
    rd(etm_pkg::REG_LEVEL, 32'h0, etm_pkg::RESP_OKAY);
    check("frames left", 0, len_q.size());
    check("frames left l3", 0, len3_q.size());
    $display("test counters done");
    conclude();
  end
endmodule
